// file: hdl/brx_consts.svh
// constants of the banked register file: sizes, modes, bits, vectors
`ifndef BRX_CONSTS_SVH
`define BRX_CONSTS_SVH

// physical storage
`define BRX_GPR_COUNT 31
`define BRX_SAVED_STATUS_WORD_COUNT 5
`define BRX_PIDX_PC 5'h1e
`define BRX_PIDX_FIQ_HI 5'h0d
`define BRX_PIDX_BANK 5'h12

// five-bit mode field values
`define BRX_MODE_USR 5'h10
`define BRX_MODE_FIQ 5'h11
`define BRX_MODE_IRQ 5'h12
`define BRX_MODE_SVC 5'h13
`define BRX_MODE_ABT 5'h17
`define BRX_MODE_UND 5'h1b
`define BRX_MODE_SYS 5'h1f

// status word bit positions
`define BRX_BIT_N 31
`define BRX_BIT_Z 30
`define BRX_BIT_C 29
`define BRX_BIT_V 28
`define BRX_BIT_Q 27
`define BRX_BIT_J 24
`define BRX_BIT_I 7
`define BRX_BIT_F 6
`define BRX_BIT_T 5
`define BRX_MODE_HI 4
`define BRX_MODE_LO 0

// status word values and masks
`define BRX_STATUS_RESET 32'h000000d3
`define BRX_FLAGS_MASK 32'hf8000000
`define BRX_SAVED_STATUS_WORD_NONE 32'h00000000

// exception vector offsets from the vector base
`define BRX_VEC_RESET 32'h00000000
`define BRX_VEC_UND 32'h00000004
`define BRX_VEC_TRAP 32'h00000008
`define BRX_VEC_PABT 32'h0000000c
`define BRX_VEC_DABT 32'h00000010
`define BRX_VEC_IRQ 32'h00000018
`define BRX_VEC_FIQ 32'h0000001c

// link offsets and program counter steps
`define BRX_LINK_4 32'h00000004
`define BRX_LINK_8 32'h00000008
`define BRX_LINK_2 32'h00000002
`define BRX_STEP_WORD 32'h00000004
`define BRX_STEP_HALF 32'h00000002
`define BRX_STEP_BYTE 32'h00000001

`endif

// file: hdl/brx_pkg.sv
// types shared by the banked register file and its exception arbiter
package brx_pkg;

  // exception requests from interrupt lines, memory and decoder
  typedef struct packed {
    logic fiq;
    logic irq;
    logic dabt;
    logic pabt;
    logic breakpoint_instr;
    logic undef;
    logic trap;
  } brx_exc_req_t;

  // which exception was taken
  typedef enum logic [2:0] {
    BRX_EXC_NONE,
    BRX_EXC_DABT,
    BRX_EXC_FIQ,
    BRX_EXC_IRQ,
    BRX_EXC_PABT,
    BRX_EXC_BREAKPOINT_INSTR,
    BRX_EXC_UNDEF,
    BRX_EXC_TRAP
  } brx_exc_t;

endpackage : brx_pkg

// file: hdl/brx_exc_prio.sv
// fixed-priority pick among pending exceptions
`timescale 1ns/100ps
module brx_exc_prio (
  input wire brx_pkg::brx_exc_req_t req,
  output logic take,
  output brx_pkg::brx_exc_t kind
);

  // fixed priority order
  // reset is handled by reset_n and outranks all of these
  always_comb begin
    take = 1'b1;
    if (req.dabt) begin
      kind = brx_pkg::BRX_EXC_DABT;
    end else if (req.fiq) begin
      kind = brx_pkg::BRX_EXC_FIQ;
    end else if (req.irq) begin
      kind = brx_pkg::BRX_EXC_IRQ;
    end else if (req.pabt) begin
      kind = brx_pkg::BRX_EXC_PABT;
    end else if (req.breakpoint_instr) begin
      kind = brx_pkg::BRX_EXC_BREAKPOINT_INSTR;
    end else if (req.undef) begin
      kind = brx_pkg::BRX_EXC_UNDEF;
    end else if (req.trap) begin
      kind = brx_pkg::BRX_EXC_TRAP;
    end else begin
      kind = brx_pkg::BRX_EXC_NONE;
      take = 1'b0;
    end
  end

endmodule : brx_exc_prio

// file: hdl/brx_regbank.sv
// banked register file with status words and exception entry
//
// How it works
// - 31 general registers, six status words.
// - fast mode banks r8-r14, others r13-r14.
// - link writes r15 into current r14.
// - r15 is the program counter.
// - one current, five saved status words.
// - entry uses target mode's r14, saved word.
// - saved word holds old flags, mode-private.
// - 16-bit state reaches r0-r7, sp, lr, pc.
// - four flags from last flag-setting operation.
// - saturation flag sticky until status write or return clears.
// - conditions never test saturation flag.
// - bytecode flag, else halfword flag selects state.
// - five-bit mode field selects visible banks.
// - exception kinds map onto their modes.
// - fixed priority among simultaneous exceptions.
// - breakpoint, undefined, trap never coincide.
// - data abort plus fast interrupt: abort, then fast.
// - disable bits gate fast and normal interrupts.
// - current word saved before mode forced.
// - entry redirects fetch to the vector.
// - link gets pc plus 2, 4 or 8.
`timescale 1ns/100ps
`include "brx_consts.svh"
module brx_regbank #(
  parameter int GPR_N = `BRX_GPR_COUNT,
  parameter int SAVED_STATUS_WORD_N = `BRX_SAVED_STATUS_WORD_COUNT,
  parameter logic [31:0] VECTOR_BASE = 32'h00000000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire brx_pkg::brx_exc_req_t exc_req,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic pc_step,
  input wire logic link_en,
  input wire logic flags_en,
  input wire logic [3:0] flags_in,
  input wire logic sat_set,
  input wire logic sw_en,
  input wire logic sw_saved,
  input wire logic [31:0] sw_data,
  input wire logic ret_en,
  input wire logic [3:0] cond_code,
  output logic cond_pass,
  output logic [31:0] pc,
  output logic [31:0] status_word,
  output logic [31:0] saved_word,
  output logic idx_fault,
  output logic exc_taken,
  output brx_pkg::brx_exc_t exc_kind
);

  logic [31:0] gpr_r [0:GPR_N-1];
  logic [31:0] gpr_nxt [0:GPR_N-1];
  logic [31:0] saved_status_word_r [0:SAVED_STATUS_WORD_N-1];
  logic [31:0] saved_status_word_nxt [0:SAVED_STATUS_WORD_N-1];
  logic [31:0] current_status_word_r, current_status_word_nxt;
  logic [31:0] rd_a_r, rd_a_nxt, rd_b_r, rd_b_nxt;
  logic [31:0] saved_r, saved_nxt;
  logic cond_r, cond_nxt;
  logic fault_r, fault_nxt;
  logic taken_r, taken_nxt;
  brx_pkg::brx_exc_t kind_r, kind_nxt;
  brx_pkg::brx_exc_req_t req_gated;
  brx_pkg::brx_exc_t pick;
  logic pick_take;
  logic [4:0] mode_cur;
  logic [2:0] bank_cur, bank_new;
  logic half_state, byte_state;
  logic [31:0] pc_cur;

  // user and system fall to bank zero
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    case (m)
      `BRX_MODE_FIQ: bank_of = 3'h1;
      `BRX_MODE_IRQ: bank_of = 3'h2;
      `BRX_MODE_SVC: bank_of = 3'h3;
      `BRX_MODE_ABT: bank_of = 3'h4;
      `BRX_MODE_UND: bank_of = 3'h5;
      default: bank_of = 3'h0;
    endcase
  endfunction : bank_of

  // logical index to physical slot
  // slots: 0-12 shared, 13-17 fast r8-r12, 18-29 r13/r14 pairs, 30 pc
  function automatic logic [4:0] phys(input logic [2:0] bank,
                                      input logic [3:0] idx);
    logic [4:0] base;
    base = `BRX_PIDX_BANK + {1'b0, bank, 1'b0};
    if (idx == 4'hf) begin
      phys = `BRX_PIDX_PC;
    end else if (idx >= 4'hd) begin
      phys = base + {4'h0, idx[0] ^ 1'b1};
    end else if (idx >= 4'h8 && bank == 3'h1) begin
      phys = `BRX_PIDX_FIQ_HI + {1'b0, idx - 4'h8};
    end else begin
      phys = {1'b0, idx};
    end
  endfunction : phys

  function automatic logic idx_ok(input logic half,
                                  input logic [3:0] idx);
    idx_ok = !half || idx < 4'h8 || idx >= 4'hd;
  endfunction : idx_ok

  // only n, z, c, v take part
  function automatic logic cond_eval(input logic [31:0] s,
                                     input logic [3:0] cc);
    logic n, z, c, v;
    n = s[`BRX_BIT_N];
    z = s[`BRX_BIT_Z];
    c = s[`BRX_BIT_C];
    v = s[`BRX_BIT_V];
    case (cc)
      4'h0: cond_eval = z;
      4'h1: cond_eval = !z;
      4'h2: cond_eval = c;
      4'h3: cond_eval = !c;
      4'h4: cond_eval = n;
      4'h5: cond_eval = !n;
      4'h6: cond_eval = v;
      4'h7: cond_eval = !v;
      4'h8: cond_eval = c && !z;
      4'h9: cond_eval = !c || z;
      4'ha: cond_eval = n == v;
      4'hb: cond_eval = n != v;
      4'hc: cond_eval = !z && (n == v);
      4'hd: cond_eval = z || (n != v);
      4'he: cond_eval = 1'b1;
      default: cond_eval = 1'b0;
    endcase
  endfunction : cond_eval

  // current view of the status word
  // bytecode flag overrides the halfword flag
  assign mode_cur = current_status_word_r[`BRX_MODE_HI:`BRX_MODE_LO];
  assign bank_cur = bank_of(mode_cur);
  assign byte_state = current_status_word_r[`BRX_BIT_J];
  assign half_state = !byte_state && current_status_word_r[`BRX_BIT_T];
  // program counter lives in slot 30
  assign pc_cur = gpr_r[`BRX_PIDX_PC];

  // disable bits gate the interrupt lines
  // abort entry leaves fast enabled, so a fast request still pending
  // is taken on the very next cycle from inside the abort handler
  always_comb begin
    req_gated = exc_req;
    req_gated.fiq = exc_req.fiq && !current_status_word_r[`BRX_BIT_F];
    req_gated.irq = exc_req.irq && !current_status_word_r[`BRX_BIT_I];
  end

  brx_exc_prio u_prio (
    .req(req_gated),
    .take(pick_take),
    .kind(pick)
  );

  // next state of registers, status words and read ports
  always_comb begin
    logic [4:0] mode_new;
    logic [31:0] vec, link_off;
    logic set_f;
    mode_new = `BRX_MODE_SVC;
    vec = `BRX_VEC_TRAP;
    link_off = `BRX_LINK_4;
    set_f = 1'b0;
    gpr_nxt = gpr_r;
    saved_status_word_nxt = saved_status_word_r;
    current_status_word_nxt = current_status_word_r;
    taken_nxt = pick_take;
    kind_nxt = pick;
    fault_nxt = 1'b0;
    // exception kind to mode, vector, link offset
    case (pick)
      brx_pkg::BRX_EXC_DABT: begin
        mode_new = `BRX_MODE_ABT;
        vec = `BRX_VEC_DABT;
        // data abort links pc plus 8
        link_off = `BRX_LINK_8;
      end
      brx_pkg::BRX_EXC_FIQ: begin
        mode_new = `BRX_MODE_FIQ;
        vec = `BRX_VEC_FIQ;
        set_f = 1'b1;
      end
      brx_pkg::BRX_EXC_IRQ: begin
        mode_new = `BRX_MODE_IRQ;
        vec = `BRX_VEC_IRQ;
      end
      brx_pkg::BRX_EXC_PABT, brx_pkg::BRX_EXC_BREAKPOINT_INSTR: begin
        mode_new = `BRX_MODE_ABT;
        vec = `BRX_VEC_PABT;
      end
      brx_pkg::BRX_EXC_UNDEF: begin
        mode_new = `BRX_MODE_UND;
        vec = `BRX_VEC_UND;
        link_off = half_state ? `BRX_LINK_2 : `BRX_LINK_4;
      end
      default: begin
        mode_new = `BRX_MODE_SVC;
        vec = `BRX_VEC_TRAP;
        link_off = half_state ? `BRX_LINK_2 : `BRX_LINK_4;
      end
    endcase
    bank_new = bank_of(mode_new);
    if (pick_take) begin
      // save old word before forcing mode
      // target mode's saved word and r14
      saved_status_word_nxt[bank_new - 3'h1] = current_status_word_r;
      // link is pc plus the kind's offset
      gpr_nxt[phys(bank_new, 4'he)] = pc_cur + link_off;
      current_status_word_nxt[`BRX_MODE_HI:`BRX_MODE_LO] = mode_new;
      current_status_word_nxt[`BRX_BIT_T] = 1'b0;
      current_status_word_nxt[`BRX_BIT_J] = 1'b0;
      current_status_word_nxt[`BRX_BIT_I] = 1'b1;
      if (set_f) begin
        current_status_word_nxt[`BRX_BIT_F] = 1'b1;
      end
      gpr_nxt[`BRX_PIDX_PC] = VECTOR_BASE + vec;
    end else begin
      // instruction side effects only when no exception is entered
      if (pc_step) begin
        gpr_nxt[`BRX_PIDX_PC] = pc_cur + (byte_state ? `BRX_STEP_BYTE :
          half_state ? `BRX_STEP_HALF : `BRX_STEP_WORD);
      end
      if (link_en) begin
        gpr_nxt[phys(bank_cur, 4'he)] = pc_cur;
      end
      // r8-r12 refused in 16-bit state; sp, lr, pc still writable
      if (wr_en && idx_ok(half_state, wr_idx)) begin
        gpr_nxt[phys(bank_cur, wr_idx)] = wr_data;
      end else if (wr_en) begin
        fault_nxt = 1'b1;
      end
      // return: saved word back into current word
      if (ret_en && bank_cur != 3'h0) begin
        current_status_word_nxt = saved_status_word_r[bank_cur - 3'h1];
      end
      if (sw_en && sw_saved) begin
        // saved word writable only in its own mode
        if (bank_cur != 3'h0) begin
          saved_status_word_nxt[bank_cur - 3'h1] = sw_data;
        end else begin
          fault_nxt = 1'b1;
        end
      end else if (sw_en) begin
        // user mode may change only the flag field
        if (bank_cur == 3'h0 && mode_cur != `BRX_MODE_SYS) begin
          current_status_word_nxt = (current_status_word_r & ~`BRX_FLAGS_MASK) |
                     (sw_data & `BRX_FLAGS_MASK);
        end else begin
          current_status_word_nxt = sw_data;
        end
      end
      if (flags_en) begin
        current_status_word_nxt[`BRX_BIT_N:`BRX_BIT_V] = flags_in;
      end
      // set wins over a same-cycle clear
      if (sat_set) begin
        current_status_word_nxt[`BRX_BIT_Q] = 1'b1;
      end
    end
    // registered reads in the current view
    rd_a_nxt = idx_ok(half_state, rd_a_idx) ?
      gpr_r[phys(bank_cur, rd_a_idx)] : 32'h00000000;
    rd_b_nxt = idx_ok(half_state, rd_b_idx) ?
      gpr_r[phys(bank_cur, rd_b_idx)] : 32'h00000000;
    if (!idx_ok(half_state, rd_a_idx) || !idx_ok(half_state, rd_b_idx)) begin
      fault_nxt = 1'b1;
    end
    // no saved word in user or system mode
    saved_nxt = (bank_cur != 3'h0) ? saved_status_word_r[bank_cur - 3'h1] :
      `BRX_SAVED_STATUS_WORD_NONE;
    cond_nxt = cond_eval(current_status_word_r, cond_code);
  end

  // storage flops; reset enters supervisor at the reset vector
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < GPR_N; i++) begin
        gpr_r[i] <= 32'h00000000;
      end
      gpr_r[`BRX_PIDX_PC] <= VECTOR_BASE + `BRX_VEC_RESET;
      // five saved words beside the current one
      for (int i = 0; i < SAVED_STATUS_WORD_N; i++) begin
        saved_status_word_r[i] <= 32'h00000000;
      end
      current_status_word_r <= `BRX_STATUS_RESET;
      rd_a_r <= 32'h00000000;
      rd_b_r <= 32'h00000000;
      saved_r <= 32'h00000000;
      cond_r <= 1'b0;
      fault_r <= 1'b0;
      taken_r <= 1'b0;
      kind_r <= brx_pkg::BRX_EXC_NONE;
    end else begin
      gpr_r <= gpr_nxt;
      saved_status_word_r <= saved_status_word_nxt;
      current_status_word_r <= current_status_word_nxt;
      rd_a_r <= rd_a_nxt;
      rd_b_r <= rd_b_nxt;
      saved_r <= saved_nxt;
      cond_r <= cond_nxt;
      fault_r <= fault_nxt;
      taken_r <= taken_nxt;
      kind_r <= kind_nxt;
    end
  end

  // outputs straight from flops
  assign rd_a_data = rd_a_r;
  assign rd_b_data = rd_b_r;
  assign pc = pc_cur;
  assign status_word = current_status_word_r;
  assign saved_word = saved_r;
  assign cond_pass = cond_r;
  assign idx_fault = fault_r;
  assign exc_taken = taken_r;
  assign exc_kind = kind_r;

endmodule : brx_regbank

// file: test/brx_regbank_assertions.sv
// port checker for the banked register file
`timescale 1ns/100ps
module brx_regbank_chk #(
  parameter logic [31:0] VECTOR_BASE = 32'h00000000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire brx_pkg::brx_exc_req_t exc_req,
  input wire logic flags_en,
  input wire logic [3:0] flags_in,
  input wire logic sw_en,
  input wire logic ret_en,
  input wire logic [3:0] cond_code,
  input wire logic cond_pass,
  input wire logic [31:0] pc,
  input wire logic [31:0] status_word,
  input wire logic exc_taken,
  input wire brx_pkg::brx_exc_t exc_kind
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // taken pulse of one kind
  sequence s_took(brx_pkg::brx_exc_t k);
    exc_taken && exc_kind == k;
  endsequence
  // abort with an open fast line, fast line still held afterwards
  sequence s_both;
    exc_req.dabt && exc_req.fiq && !status_word[6] ##1 exc_req.fiq;
  endsequence
  property p_irq_entry;
    s_took(brx_pkg::BRX_EXC_IRQ) |-> pc == VECTOR_BASE + 32'h00000018
      && status_word[4:0] == 5'h12 && status_word[7];
  endproperty
  property p_fiq_entry;
    s_took(brx_pkg::BRX_EXC_FIQ) |-> pc == VECTOR_BASE + 32'h0000001c
      && status_word[4:0] == 5'h11 && status_word[7] && status_word[6];
  endproperty
  property p_dabt_entry;
    s_took(brx_pkg::BRX_EXC_DABT) |-> pc == VECTOR_BASE + 32'h00000010
      && status_word[4:0] == 5'h17;
  endproperty
  property p_trap_entry;
    s_took(brx_pkg::BRX_EXC_TRAP) |-> pc == VECTOR_BASE + 32'h00000008
      && status_word[4:0] == 5'h13;
  endproperty
  property p_dabt_first;
    exc_req.dabt |=> s_took(brx_pkg::BRX_EXC_DABT);
  endproperty
  property p_fiq_next;
    s_both |=> s_took(brx_pkg::BRX_EXC_FIQ);
  endproperty
  property p_gate;
    status_word[7] && status_word[6] && exc_req[4:0] == 5'h00 |=> !exc_taken;
  endproperty
  property p_sat_sticky;
    status_word[27] && !sw_en && !ret_en |=> status_word[27];
  endproperty
  property p_flags_load;
    flags_en && !sw_en && !ret_en && exc_req == 7'h00
      |=> status_word[31:28] == $past(flags_in);
  endproperty
  property p_cond_eq;
    cond_code == 4'h0 |=> cond_pass == $past(status_word[30]);
  endproperty
  a_irq_entry: assert property (p_irq_entry)
    else $error("irq entry state wrong");
  a_fiq_entry: assert property (p_fiq_entry)
    else $error("fiq entry state wrong");
  a_dabt_entry: assert property (p_dabt_entry)
    else $error("abort entry state wrong");
  a_trap_entry: assert property (p_trap_entry)
    else $error("trap entry state wrong");
  a_dabt_first: assert property (p_dabt_first)
    else $error("data abort not taken first");
  a_fiq_next: assert property (p_fiq_next)
    else $error("fiq not taken after abort");
  a_gate: assert property (p_gate)
    else $error("masked interrupt taken");
  a_sat_sticky: assert property (p_sat_sticky)
    else $error("saturation flag dropped");
  a_flags_load: assert property (p_flags_load)
    else $error("flags not loaded");
  a_cond_eq: assert property (p_cond_eq)
    else $error("equal condition wrong");
endmodule : brx_regbank_chk

bind brx_regbank brx_regbank_chk #(.VECTOR_BASE(VECTOR_BASE)) u_chk (.*);

// file: test/brx_exc_src.sv
// exception source model: each request held until the core takes it
`timescale 1ns/100ps
module brx_exc_src (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire brx_pkg::brx_exc_req_t raise,
  input wire logic exc_taken,
  input wire brx_pkg::brx_exc_t exc_kind,
  output brx_pkg::brx_exc_req_t exc_req
);
  logic [6:0] pend_r;
  logic [6:0] done;
  // one-hot of the kind just taken, in request bit order
  always_comb begin
    done = 7'h00;
    if (exc_taken) begin
      case (exc_kind)
        brx_pkg::BRX_EXC_FIQ: done = 7'h40;
        brx_pkg::BRX_EXC_IRQ: done = 7'h20;
        brx_pkg::BRX_EXC_DABT: done = 7'h10;
        brx_pkg::BRX_EXC_PABT: done = 7'h08;
        brx_pkg::BRX_EXC_BREAKPOINT_INSTR: done = 7'h04;
        brx_pkg::BRX_EXC_UNDEF: done = 7'h02;
        default: done = {6'h00, exc_kind == brx_pkg::BRX_EXC_TRAP};
      endcase
    end
  end
  // fast line held
  // taken line drops at once so it is not sampled twice
  assign exc_req = brx_pkg::brx_exc_req_t'(pend_r & ~done);
  // pending lines
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      pend_r <= 7'h00;
    else
      pend_r <= (pend_r & ~done) | raise;
  end
endmodule : brx_exc_src

// file: test/brx_regbank_test.sv
// self-checking bench for the banked register file
`timescale 1ns/100ps
module brx_regbank_test;
  typedef struct packed {
    brx_pkg::brx_exc_t kind;
    logic [31:0] pc;
    logic [4:0] mode;
  } brx_note_t;
  localparam logic [31:0] VB = 32'h00010000;
  logic clk_sys, reset_n, wr_en, pc_step, link_en, flags_en, sat_set;
  logic sw_en, sw_saved, ret_en, cond_pass, idx_fault, exc_taken;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx, flags_in, cond_code;
  logic [31:0] wr_data, sw_data, rd_a_data, rd_b_data, pc, d1;
  logic [31:0] status_word, saved_word, seed;
  brx_pkg::brx_exc_req_t exc_req, raise;
  brx_pkg::brx_exc_t exc_kind;
  brx_note_t exp_q[$];
  brx_note_t nt;
  int num_errors, total_checks, cycles;
  brx_pkg::brx_exc_t kinds[4] = '{brx_pkg::BRX_EXC_UNDEF,
    brx_pkg::BRX_EXC_BREAKPOINT_INSTR, brx_pkg::BRX_EXC_TRAP, brx_pkg::BRX_EXC_IRQ};
  logic [6:0] lines[4] = '{7'h02, 7'h04, 7'h01, 7'h20};
  logic [31:0] vecs[4] = '{32'h04, 32'h0c, 32'h08, 32'h18};
  logic [4:0] modes[4] = '{5'h1b, 5'h17, 5'h13, 5'h12};

  brx_regbank #(.VECTOR_BASE(VB)) DUT (.clk_sys(clk_sys),
    .reset_n(reset_n), .exc_req(exc_req), .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .pc_step(pc_step),
    .link_en(link_en), .flags_en(flags_en), .flags_in(flags_in),
    .sat_set(sat_set), .sw_en(sw_en), .sw_saved(sw_saved),
    .sw_data(sw_data), .ret_en(ret_en), .cond_code(cond_code),
    .cond_pass(cond_pass), .pc(pc), .status_word(status_word),
    .saved_word(saved_word), .idx_fault(idx_fault),
    .exc_taken(exc_taken), .exc_kind(exc_kind));
  brx_exc_src src (.clk_sys(clk_sys), .reset_n(reset_n), .raise(raise),
    .exc_taken(exc_taken), .exc_kind(exc_kind), .exc_req(exc_req));

  // free-running core clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected pass of a condition code on flags n z c v
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cr, v;
    {n, z, cr, v} = f;
    case (c[3:1])
      3'h0: cond_ok = z;
      3'h1: cond_ok = cr;
      3'h2: cond_ok = n;
      3'h3: cond_ok = v;
      3'h4: cond_ok = cr & ~z;
      3'h5: cond_ok = n == v;
      3'h6: cond_ok = ~z & (n == v);
      default: cond_ok = 1'b1;
    endcase
    // odd codes invert, so the last code never passes
    cond_ok = cond_ok ^ c[0];
  endfunction : cond_ok

  // one instruction cycle; en = wr, sw, ret, flags, sat
  task issue(input logic [4:0] en, input logic [3:0] i,
             input logic [31:0] d);
    @(posedge clk_sys);
    {wr_en, sw_en, ret_en, flags_en, sat_set} <= en;
    wr_idx <= i;
    wr_data <= d;
    sw_data <= d;
    flags_in <= d[31:28];
    @(posedge clk_sys);
    {wr_en, sw_en, ret_en, flags_en, sat_set} <= 5'h00;
  endtask : issue

  task rd(input logic [3:0] i, input logic [31:0] want, input string what);
    @(posedge clk_sys);
    rd_a_idx <= i;
    rd_b_idx <= i;
    @(posedge clk_sys);
    #1;
    check(what, rd_a_data, want);
    check(what, rd_b_data, want);
  endtask : rd

  task exc(input logic [6:0] bits, input int k);
    if (k >= 0)
      exp_q.push_back('{kinds[k], VB + vecs[k], modes[k]});
    @(posedge clk_sys);
    raise <= brx_pkg::brx_exc_req_t'(bits);
    @(posedge clk_sys);
    raise <= 7'h00;
  endtask : exc

  // bounded wait until every noted entry was seen
  task drain;
    for (int n = 0; n < 40 && exp_q.size() != 0; n++)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    check("missing entries", 32'(exp_q.size()), 32'h0);
  endtask : drain

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // each taken pulse against the oldest note
  always @(posedge clk_sys) begin
    if (reset_n === 1'b1 && exc_taken === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected entry", 32'(exc_kind), 32'h0);
      else begin
        nt = exp_q.pop_front();
        check("entry kind", 32'(exc_kind), 32'(nt.kind));
        check("entry pc", pc, nt.pc);
        check("entry mode", 32'(status_word[4:0]), 32'(nt.mode));
      end
    end
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    seed = 32'hd4597891;
    {wr_en, sw_en, ret_en, flags_en, sat_set} = 5'h00;
    {pc_step, link_en, sw_saved} = 3'h0;
    {rd_a_idx, rd_b_idx, wr_idx, flags_in, cond_code} = 20'h00000;
    {wr_data, sw_data} = 64'h0;
    raise = 7'h00;
    reset_n = 1'b0;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("reset pc", pc, VB);
    check("reset status", status_word, 32'h000000d3);
    // open both interrupt lines, then raise five kinds at once
    issue(5'h08, 4'h0, 32'h00000013);
    exp_q.push_back('{brx_pkg::BRX_EXC_DABT, VB + 32'h10, 5'h17});
    exp_q.push_back('{brx_pkg::BRX_EXC_FIQ, VB + 32'h1c, 5'h11});
    exp_q.push_back('{brx_pkg::BRX_EXC_PABT, VB + 32'h0c, 5'h17});
    exc(7'h79, 2);
    drain;
    rd(4'he, VB + 32'h10, "trap link");
    // irq stayed masked; user mode with lines open lets it in
    exp_q.push_back('{brx_pkg::BRX_EXC_IRQ, VB + 32'h18, 5'h12});
    issue(5'h08, 4'h0, 32'h00000010);
    drain;
    check("saved word", saved_word, 32'h00000010);
    rd(4'he, VB + 32'h0c, "irq link");
    issue(5'h04, 4'h0, 32'h0);
    #1;
    check("returned", status_word, 32'h00000010);
    d1 = rnd();
    issue(5'h10, 4'h8, d1);
    exp_q.push_back('{brx_pkg::BRX_EXC_FIQ, VB + 32'h1c, 5'h11});
    exc(7'h40, -1);
    drain;
    rd(4'h8, 32'h0, "fast r8");
    issue(5'h04, 4'h0, 32'h0);
    rd(4'h8, d1, "user r8");
    // three decode kinds, then irq, one at a time
    for (int k = 0; k < 4; k++) begin
      exc(lines[k], k);
      drain;
      issue(5'h04, 4'h0, 32'h0);
    end
    issue(5'h01, 4'h0, 32'h0);
    for (int r = 0; r < 6; r++) begin
      d1 = rnd();
      issue(5'h02, 4'h0, d1);
      for (int c = 0; c < 16; c++) begin
        @(posedge clk_sys);
        cond_code <= c[3:0];
        @(posedge clk_sys);
        #1;
        check("cond", 32'(cond_pass), 32'(cond_ok(c[3:0], d1[31:28])));
      end
      check("flags", 32'(status_word[31:27]), {27'h0, d1[31:28], 1'b1});
    end
    // user status write reaches the flags only
    issue(5'h08, 4'h0, 32'h0000001f);
    #1;
    check("flag clear", status_word, 32'h00000010);
    // saved-word write refused in user mode; link and step in one cycle
    @(posedge clk_sys);
    {sw_en, sw_saved, link_en, pc_step} <= 4'hf;
    @(posedge clk_sys);
    {sw_en, sw_saved, link_en, pc_step} <= 4'h0;
    #1;
    check("saved write fault", 32'(idx_fault), 32'h1);
    check("status kept", status_word, 32'h00000010);
    check("pc step", pc, VB + 32'h1c);
    rd(4'he, VB + 32'h18, "link");
    give_verdict();
  end
endmodule : brx_regbank_test
